// ==== pkg/cpil_pkg.sv ====
// Constants and types shared by the cascaded interrupt controller pair.
package cpil_pkg;
  // Port offsets on the peripheral bus.
  localparam logic [2:0] OFS_MASTER_PORT_ZERO = 3'h0;
  localparam logic [2:0] OFS_MASTER_PORT_ONE = 3'h2;
  localparam logic [2:0] OFS_SLAVE_PORT_ZERO = 3'h4;
  localparam logic [2:0] OFS_SLAVE_PORT_ONE = 3'h6;
  // Address bit positions: controller choice and the port-select line.
  localparam int ADDR_CTL_BIT = 2;
  localparam int ADDR_PORT_BIT = 1;
  // First initialization word fields.
  localparam int INIT_START_BIT = 4;
  localparam int LEVEL_MODE_BIT = 3;
  localparam int SINGLE_CONTROLLER_BIT = 1;
  localparam int FOURTH_WORD_NEEDED_BIT = 0;
  // Fourth initialization word fields.
  localparam int NESTED_MODE_BIT = 4;
  localparam int AUTO_END_BIT = 1;
  // Operational command fields on port zero.
  localparam int CMD_SELECT_BIT = 3;
  localparam int END_OF_SERVICE_BIT = 5;
  localparam int SPECIAL_MASK_ACT_BIT = 6;
  localparam int SPECIAL_MASK_VAL_BIT = 5;
  localparam int READ_ACT_BIT = 1;
  localparam int READ_SERVICE_BIT = 0;
  // Values forced when initialization starts and after reset, and the master input that carries the slave.
  localparam logic [7:0] MASK_CLEARED = 8'h00;
  localparam logic [7:0] MASK_AT_RESET = 8'hff;
  localparam logic [7:0] EDGE_HISTORY_HIGH = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] DEF_TOP_PRIORITY = 3'h7;
  localparam logic [2:0] DEF_SLAVE_ID = 3'h7;
  localparam logic [2:0] CASCADE_INPUT = 3'h7;
  // Initialization sequence states.
  typedef enum logic [2:0] {
    CPIL_UNINIT,
    CPIL_WAIT_SECOND,
    CPIL_WAIT_THIRD,
    CPIL_WAIT_FOURTH,
    CPIL_READY
  } cpil_init_t;
endpackage

// ==== rtl/cpil_prio.sv ====
// Rotating priority picker: finds the best set bit counted from a top position.
`timescale 1ns/100ps
module cpil_prio (
  // Candidate bits and the position that ranks highest.
  input wire logic [7:0] vec,
  input wire logic [2:0] top,
  // Winner.
  output logic found,
  output logic [2:0] idx,
  output logic [2:0] rank
);
  logic [15:0] doubled;
  logic [7:0] rotated;

  // Rotate so that the top position lands at bit zero.
  assign doubled = {vec, vec};
  assign rotated = doubled[top +: 8];

  // Lowest set bit of the rotated vector is the winner.
  always_comb begin
    found = 1'b0;
    rank = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (rotated[i]) begin
        found = 1'b1;
        rank = 3'(i);
      end
    end
  end

  // The sum wraps on purpose: positions count modulo eight.
  assign idx = 3'(rank + top);
endmodule

// ==== rtl/cpil_top.sv ====
// Cascaded pair of interrupt controllers with initialization sequencing.
`timescale 1ns/100ps
module cpil_top import cpil_pkg::*; #(
  parameter int NUM_LINES = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Peripheral register bus.
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Request lines.
  input wire logic [6:0] req_master,
  input wire logic [7:0] req_slave,
  // Core side.
  input wire logic core_ack,
  output logic core_maskable_request,
  output logic [7:0] int_type,
  output logic int_type_valid
);
  // The per-bit logic below is written for exactly eight request lines.
  if (NUM_LINES != 8) begin : g_bad_width
    $error("cpil_top supports only eight request lines");
  end

  // Per-controller state; index 0 is the master, index 1 the slave.
  cpil_init_t init_st [2];
  logic [7:0] pending_request_register [2];
  logic [7:0] isr [2];
  logic [7:0] mask [2];
  logic [7:0] prev [2];
  logic [7:0] base [2];
  logic [7:0] cas_cfg [2];
  logic [2:0] top_prio [2];
  logic [2:0] slave_id [2];
  logic level_mode [2];
  logic want_third [2];
  logic want_fourth [2];
  logic auto_end [2];
  logic nested [2];
  logic special_mask [2];
  logic read_service [2];
  logic slave_int;

  // Per-controller decode and priority wires.
  logic [7:0] lines [2];
  logic [7:0] pend [2];
  logic [7:0] isr_eff [2];
  logic [7:0] rd_byte [2];
  logic req_found [2];
  logic [2:0] req_idx [2];
  logic [2:0] req_rank [2];
  logic srv_found [2];
  logic [2:0] srv_idx [2];
  logic [2:0] srv_rank [2];
  logic fire [2];
  logic ready [2];
  logic wr_p0 [2];
  logic wr_p1 [2];
  logic start [2];
  logic oper_p0 [2];
  logic eoi_cmd [2];
  logic ack_take [2];

  // Acknowledge routing between master and slave.
  logic m_found;
  logic casc_ack;
  logic [7:0] next_type;
  logic [7:0] rd_mux;

  // Request lines: the slave's output sits on master input seven.
  assign lines[0] = {slave_int, req_master};
  assign lines[1] = req_slave;

  // Master wins the acknowledge; a cascaded win hands the type to the slave.
  assign m_found = ready[0] && req_found[0];
  assign casc_ack = m_found && (req_idx[0] == CASCADE_INPUT) && cas_cfg[0][CASCADE_INPUT]
                    && ready[1] && req_found[1] && (slave_id[1] == CASCADE_INPUT);
  assign ack_take[0] = core_ack && m_found;
  assign ack_take[1] = core_ack && casc_ack;

  // Type is base plus line; with no request the master reports line seven.
  assign next_type = casc_ack ? 8'(base[1] + {5'h00, req_idx[1]})
                   : m_found ? 8'(base[0] + {5'h00, req_idx[0]})
                   : 8'(base[0] + {5'h00, CASCADE_INPUT});

  // Read data: port-select line picks status or mask, address bit two the controller.
  assign rd_mux = bus_addr[0] ? BYTE_ZERO : rd_byte[bus_addr[ADDR_CTL_BIT]];

  for (genvar g = 0; g < 2; g++) begin : g_ctl
    cpil_init_t next_st;
    logic wr_here;

    // Write decode from port, data and sequence position.
    assign wr_here = bus_wr && (bus_addr[ADDR_CTL_BIT] == 1'(g)) && !bus_addr[0];
    assign wr_p0[g] = wr_here && !bus_addr[ADDR_PORT_BIT];
    assign wr_p1[g] = wr_here && bus_addr[ADDR_PORT_BIT];
    assign start[g] = wr_p0[g] && bus_wdata[INIT_START_BIT];
    assign ready[g] = (init_st[g] == CPIL_READY);
    assign oper_p0[g] = wr_p0[g] && !bus_wdata[INIT_START_BIT] && ready[g];
    assign eoi_cmd[g] = oper_p0[g] && !bus_wdata[CMD_SELECT_BIT]
                        && bus_wdata[END_OF_SERVICE_BIT];

    // Pending unmasked requests and the in-service levels that block them.
    assign pend[g] = pending_request_register[g] & ~mask[g];
    assign isr_eff[g] = special_mask[g] ? (isr[g] & ~mask[g]) : isr[g];
    assign rd_byte[g] = bus_addr[ADDR_PORT_BIT] ? mask[g]
                      : (read_service[g] ? isr[g] : pending_request_register[g]);

    cpil_prio u_req (
      .vec(pend[g]),
      .top(top_prio[g]),
      .found(req_found[g]),
      .idx(req_idx[g]),
      .rank(req_rank[g])
    );

    cpil_prio u_srv (
      .vec(isr_eff[g]),
      .top(top_prio[g]),
      .found(srv_found[g]),
      .idx(srv_idx[g]),
      .rank(srv_rank[g])
    );

    // A request fires while it outranks every level in service and not special-masked, or, on the master in nested mode, ties an in-service cascaded input.
    assign fire[g] = ready[g] && req_found[g] && (!srv_found[g] || req_rank[g] < srv_rank[g]
                     || ((g == 0) && nested[g] && cas_cfg[g][req_idx[g]]
                         && req_idx[g] == srv_idx[g]));

    // Sequence position for the next port-one write.
    always_comb begin
      next_st = init_st[g];
      case (init_st[g])
        CPIL_UNINIT: next_st = CPIL_UNINIT;
        CPIL_WAIT_SECOND: begin
          if (wr_p1[g]) begin
            next_st = want_third[g] ? CPIL_WAIT_THIRD
                    : (want_fourth[g] ? CPIL_WAIT_FOURTH : CPIL_READY);
          end
        end
        CPIL_WAIT_THIRD: begin
          if (wr_p1[g]) begin
            next_st = want_fourth[g] ? CPIL_WAIT_FOURTH : CPIL_READY;
          end
        end
        CPIL_WAIT_FOURTH: begin
          if (wr_p1[g]) begin
            next_st = CPIL_READY;
          end
        end
        CPIL_READY: next_st = CPIL_READY;
        default: next_st = CPIL_UNINIT;
      endcase
      if (start[g]) begin
        next_st = CPIL_WAIT_SECOND;
      end
    end

    // Sequence state and the first-word settings.
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        init_st[g] <= CPIL_UNINIT;
        level_mode[g] <= 1'b0;
        want_third[g] <= 1'b0;
        want_fourth[g] <= 1'b0;
      end else begin
        init_st[g] <= next_st;
        if (start[g]) begin
          level_mode[g] <= bus_wdata[LEVEL_MODE_BIT];
          want_third[g] <= !bus_wdata[SINGLE_CONTROLLER_BIT];
          want_fourth[g] <= bus_wdata[FOURTH_WORD_NEEDED_BIT];
        end
      end
    end

    // Later words, the mask and command settings.
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        base[g] <= BYTE_ZERO;
        cas_cfg[g] <= BYTE_ZERO;
        slave_id[g] <= DEF_SLAVE_ID;
        top_prio[g] <= DEF_TOP_PRIORITY;
        auto_end[g] <= 1'b0;
        nested[g] <= 1'b0;
        mask[g] <= MASK_AT_RESET;
        special_mask[g] <= 1'b0;
        read_service[g] <= 1'b0;
      end else if (start[g]) begin
        mask[g] <= MASK_CLEARED;
        top_prio[g] <= DEF_TOP_PRIORITY;
        slave_id[g] <= DEF_SLAVE_ID;
        special_mask[g] <= 1'b0;
        read_service[g] <= 1'b0;
        auto_end[g] <= 1'b0;
        nested[g] <= 1'b0;
      end else if (wr_p1[g]) begin
        case (init_st[g])
          CPIL_WAIT_SECOND: base[g] <= bus_wdata;
          CPIL_WAIT_THIRD: begin
            cas_cfg[g] <= bus_wdata;
            slave_id[g] <= bus_wdata[2:0];
          end
          CPIL_WAIT_FOURTH: begin
            nested[g] <= bus_wdata[NESTED_MODE_BIT];
            auto_end[g] <= bus_wdata[AUTO_END_BIT];
          end
          CPIL_READY: mask[g] <= bus_wdata;
          default: mask[g] <= mask[g];
        endcase
      end else if (oper_p0[g] && bus_wdata[CMD_SELECT_BIT]) begin
        if (bus_wdata[SPECIAL_MASK_ACT_BIT]) begin
          special_mask[g] <= bus_wdata[SPECIAL_MASK_VAL_BIT];
        end
        if (bus_wdata[READ_ACT_BIT]) begin
          read_service[g] <= bus_wdata[READ_SERVICE_BIT];
        end
      end
    end

    // Edge history, pending and in-service bits; a set beats a clear.
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        prev[g] <= EDGE_HISTORY_HIGH;
        pending_request_register[g] <= BYTE_ZERO;
        isr[g] <= BYTE_ZERO;
      end else if (start[g]) begin
        prev[g] <= EDGE_HISTORY_HIGH;
        pending_request_register[g] <= BYTE_ZERO;
        isr[g] <= BYTE_ZERO;
      end else begin
        prev[g] <= lines[g];
        if (level_mode[g]) begin
          pending_request_register[g] <= lines[g];
        end else begin
          pending_request_register[g] <= (pending_request_register[g] & ~(ack_take[g] ? (8'h01 << req_idx[g]) : BYTE_ZERO))
                    | (lines[g] & ~prev[g]);
        end
        isr[g] <= (isr[g] & ~(eoi_cmd[g] && srv_found[g] ? (8'h01 << srv_idx[g]) : BYTE_ZERO))
                  | (ack_take[g] && !auto_end[g] ? (8'h01 << req_idx[g]) : BYTE_ZERO);
      end
    end

    // The first word always leads to the wait for the second word.
    chk_second_after_start: assert property (@(posedge core_clk) disable iff (sys_rst)
      start[g] |=> init_st[g] == CPIL_WAIT_SECOND)
      else $error("first word did not lead to the second-word wait");

    // Start forces the documented defaults one cycle later.
    chk_start_defaults: assert property (@(posedge core_clk) disable iff (sys_rst)
      start[g] |=> mask[g] == MASK_CLEARED && top_prio[g] == DEF_TOP_PRIORITY)
      else $error("initialization start left mask or priority unchanged");

    chk_start_slave_id: assert property (@(posedge core_clk) disable iff (sys_rst)
      start[g] |=> slave_id[g] == DEF_SLAVE_ID && !special_mask[g] && !read_service[g])
      else $error("initialization start left identity or read mode unchanged");

    // After an edge-mode start nothing is pending, not even a line held high.
    chk_edge_fresh: assert property (@(posedge core_clk) disable iff (sys_rst)
      start[g] ##1 (!start[g] && !level_mode[g]) |=> pending_request_register[g] == BYTE_ZERO)
      else $error("held line counted as a new request after start");

    // The fourth word, when it is awaited, leaves initialization.
    chk_ready_after_last: assert property (@(posedge core_clk) disable iff (sys_rst)
      init_st[g] == CPIL_WAIT_FOURTH && wr_p1[g] && !start[g] |=> ready[g])
      else $error("fourth word did not finish initialization");

    chk_base_taken: assert property (@(posedge core_clk) disable iff (sys_rst)
      init_st[g] == CPIL_WAIT_SECOND && wr_p1[g] && !start[g] |=> base[g] == $past(bus_wdata))
      else $error("second word was not stored as the base type");
  end

  // Slave output, core request, type and read data all leave from flops.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slave_int <= 1'b0;
      core_maskable_request <= 1'b0;
      int_type <= BYTE_ZERO;
      int_type_valid <= 1'b0;
      bus_rdata <= BYTE_ZERO;
    end else begin
      slave_int <= fire[1];
      core_maskable_request <= fire[0];
      int_type_valid <= core_ack;
      if (core_ack) begin
        int_type <= next_type;
      end
      bus_rdata <= bus_rd ? rd_mux : BYTE_ZERO;
    end
  end

  // The core request follows the master's outranking decision by one cycle.
  chk_core_request: assert property (@(posedge core_clk) disable iff (sys_rst)
    core_maskable_request == $past(fire[0]) && (!core_maskable_request || $past(ready[0])))
    else $error("core request not tied to an outranking master request");

  // The returned type is the base plus the winning line.
  chk_type_value: assert property (@(posedge core_clk) disable iff (sys_rst)
    core_ack && m_found && !casc_ack |=> int_type_valid
      && int_type == 8'($past(base[0]) + {5'h00, $past(req_idx[0])}))
    else $error("acknowledged type differs from base plus line");
endmodule

// ==== test/cpil_core_model.sv ====
// Behavioural processor core that acknowledges the controller's maskable request.
`timescale 1ns/100ps
module cpil_core_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Controller side.
  input wire logic core_maskable_request,
  input wire logic [7:0] int_type,
  input wire logic int_type_valid,
  output logic core_ack,
  // Bench side.
  input wire logic core_en,
  input wire logic [3:0] ack_delay,
  output logic [7:0] last_type,
  output logic [9:0] vec_addr,
  output int n_acks
);
  logic [3:0] wait_cnt;
  logic cool;
  logic busy;

  // Acknowledge after the chosen delay, then skip one cycle so the stale request is not taken.
  always_ff @(posedge core_clk) begin
    core_ack <= 1'b0;
    if (sys_rst) begin
      wait_cnt <= 4'h0;
      cool <= 1'b0;
      busy <= 1'b0;
      n_acks <= 0;
      last_type <= 8'h00;
      vec_addr <= 10'h000;
    end else if (int_type_valid) begin
      last_type <= int_type;
      vec_addr <= {int_type, 2'b00};
      n_acks <= n_acks + 1;
      cool <= 1'b1;
    end else if (cool) begin
      cool <= 1'b0;
      busy <= 1'b0;
    end else if (!busy && core_en && core_maskable_request) begin
      if (wait_cnt >= ack_delay) begin
        core_ack <= 1'b1;
        busy <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule

// ==== test/cpil_top_bench.sv ====
// Self-checking bench for the cascaded controller pair and its setup sequence.
`timescale 1ns/100ps
module cpil_top_bench import cpil_pkg::*;;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic [6:0] req_master = 7'h00;
  logic [7:0] req_slave = 8'h00;
  logic core_ack;
  logic core_maskable_request;
  logic [7:0] int_type;
  logic int_type_valid;
  logic core_en = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic [7:0] last_type;
  logic [9:0] vec_addr;
  int n_acks;
  int n_errors = 0;
  int checks = 0;

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  cpil_top u_cpil_top (.core_clk(core_clk), .sys_rst(sys_rst), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .req_master(req_master),
    .req_slave(req_slave), .core_ack(core_ack), .core_maskable_request(core_maskable_request),
    .int_type(int_type), .int_type_valid(int_type_valid));

  cpil_core_model u_cpil_core_model (.core_clk(core_clk), .sys_rst(sys_rst),
    .core_maskable_request(core_maskable_request), .int_type(int_type),
    .int_type_valid(int_type_valid), .core_ack(core_ack), .core_en(core_en),
    .ack_delay(ack_delay), .last_type(last_type), .vec_addr(vec_addr), .n_acks(n_acks));

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    step;
    bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    step;
    bus_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    step;
    bus_rd = 1'b1;
    bus_addr = a;
    step;
    bus_rd = 1'b0;
    check(16'(bus_rdata), 16'(exp), what);
  endtask

  // Four-word setup; the fourth value would show up as a mask if taken as one.
  task automatic init_ctl(input logic [2:0] p0, input logic [7:0] base, input logic [7:0] third);
    wr(p0, 8'h11);
    wr(p0 + 3'h2, base);
    wr(p0 + 3'h2, third);
    wr(p0 + 3'h2, 8'h0c);
  endtask

  task automatic wait_ack(input logic [7:0] exp);
    int start;
    start = n_acks;
    for (int i = 0; i < 60 && n_acks == start; i++) step;
    if (n_acks == start) begin
      n_errors++;
      $display("MISMATCH acknowledge expected 1 seen 0");
      report_and_stop;
    end else begin
      check(16'(last_type), 16'(exp), "int_type");
      check(16'(vec_addr), 16'({exp, 2'b00}), "vector");
    end
  endtask

  task automatic no_ack(input int cycles);
    int start;
    start = n_acks;
    repeat (cycles) step;
    check(16'(n_acks - start), 16'h0000, "ack count");
    check(16'(core_maskable_request), 16'h0000, "request");
  endtask

  task automatic s_reset;
    check(16'(int_type_valid), 16'h0000, "type valid");
    core_en = 1'b1;
    req_master[2] = 1'b1;
    no_ack(10);
    req_master[2] = 1'b0;
    core_en = 1'b0;
  endtask

  task automatic s_init;
    init_ctl(OFS_MASTER_PORT_ZERO, 8'h20, 8'h80);
    init_ctl(OFS_SLAVE_PORT_ZERO, 8'h40, 8'h07);
    rd(OFS_MASTER_PORT_ONE, 8'h00, "master mask");
    rd(OFS_SLAVE_PORT_ONE, 8'h00, "slave mask");
    rd(OFS_MASTER_PORT_ZERO, 8'h00, "master pending");
    rd(3'h1, 8'h00, "unmapped");
    wr(OFS_SLAVE_PORT_ONE, 8'h5a);
    rd(OFS_SLAVE_PORT_ONE, 8'h5a, "slave mask");
    rd(OFS_MASTER_PORT_ONE, 8'h00, "master mask");
    wr(OFS_SLAVE_PORT_ONE, 8'h00);
    core_en = 1'b1;
  endtask

  task automatic s_single;
    req_master[3] = 1'b1;
    wait_ack(8'h23);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    req_master[3] = 1'b0;
  endtask

  // Slow core lets both sources become pending; the slave on input seven must win.
  task automatic s_cascade;
    ack_delay = 4'h6;
    req_master[0] = 1'b1;
    req_slave[2] = 1'b1;
    wait_ack(8'h42);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    wait_ack(8'h20);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    wr(OFS_SLAVE_PORT_ZERO, 8'h20);
    req_master[0] = 1'b0;
    req_slave[2] = 1'b0;
    ack_delay = 4'h0;
  endtask

  task automatic s_nest;
    req_master[3] = 1'b1;
    wait_ack(8'h23);
    req_master[5] = 1'b1;
    no_ack(20);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    wait_ack(8'h25);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    req_master[3] = 1'b0;
    req_master[5] = 1'b0;
  endtask

  task automatic s_mask;
    wr(OFS_MASTER_PORT_ONE, 8'h02);
    req_master[1] = 1'b1;
    no_ack(10);
    rd(OFS_MASTER_PORT_ZERO, 8'h02, "master pending");
    wr(OFS_MASTER_PORT_ONE, 8'h00);
    wait_ack(8'h21);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
  endtask

  // Abandon a half-done setup while input one is held high; it drops only to make fresh rises.
  task automatic s_restart;
    core_en = 1'b0;
    wr(OFS_MASTER_PORT_ONE, 8'hff);
    // A fresh rise while masked leaves input one pending; the restart must drop it.
    req_master[1] = 1'b0;
    step;
    req_master[1] = 1'b1;
    rd(OFS_MASTER_PORT_ZERO, 8'h02, "master pending");
    wr(OFS_MASTER_PORT_ZERO, 8'h11);
    wr(OFS_MASTER_PORT_ONE, 8'h60);
    init_ctl(OFS_MASTER_PORT_ZERO, 8'h30, 8'h80);
    rd(OFS_MASTER_PORT_ONE, 8'h00, "master mask");
    core_en = 1'b1;
    no_ack(20);
    req_master[1] = 1'b0;
    step;
    req_master[1] = 1'b1;
    wait_ack(8'h31);
    wr(OFS_MASTER_PORT_ZERO, 8'h20);
    req_master[1] = 1'b0;
  endtask

  // Reset, then the scenarios in order.
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    s_reset;
    s_init;
    s_single;
    s_cascade;
    s_nest;
    s_mask;
    s_restart;
    report_and_stop;
  end
endmodule
